/* hdl/adc_seq_cfg.svh */
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// register offsets on the plain register port
`define ADC_RESULT_OFS 8'h70
`define ADC_CTRL_OFS 8'h71

// control/status field positions
`define ADC_DONE_BIT 7
`define ADC_PWR_BIT 5
`define ADC_CHAN_MSB 2
`define ADC_CHAN_LSB 0

// reset values
`define ADC_RESULT_RST 8'h00
`define ADC_CTRL_RST 8'h00

// timing
`define ADC_CLK_PERIOD_PS 5000
`define ADC_STAB_TIME_US 30
`define ADC_STAB_CYCLES ((`ADC_STAB_TIME_US * 1000000 + `ADC_CLK_PERIOD_PS - 1) / `ADC_CLK_PERIOD_PS)
`define ADC_CONV_CYCLES 64
`define ADC_SAMPLE_CYCLES 32
`define ADC_SLOT_CYCLES 4

`endif

/* hdl/adc_seq_pkg.sv */
package adc_seq_pkg;

  typedef enum logic [1:0] {ST_OFF, ST_STAB, ST_CONV} adcState_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } regReq_s;

  typedef struct packed {
    logic powerOn;
    logic sampling;
    logic [2:0] channel;
    logic [7:0] trial;
  } analogCtl_s;

endpackage

/* hdl/adc_sequencer_control.sv */
// Operation
// - three-bit channel field picks analog input n for code n
// - power-on bit waits stabilization delay, then converts continuously without triggers
// - each conversion lasts 64 clocks, sampling phase the first 32 of them
// - conversion end sets done flag bit 7 and loads 8-bit result
// - conversion end raises no interrupt; software polls the done flag
// - control write aborts conversion, clears done flag, restarts with new settings
// - reading the result clears the done flag
// - clearing power-on bit switches converter off and stops conversions
// - light sleep mode leaves the converter running
// - deep sleep disables converter; restabilize after exit before converting
// - input at or above high reference gives FFh, below low gives 00h
// - result register read-only, unsigned 8 bits, resets to zero
// - control bit 4 always reads zero
// - power-on bit is bit 5, read-write, resets to zero
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_sequencer_control #(
  parameter int STAB_CYCLES = `ADC_STAB_CYCLES
) (
  input wire logic core_clk, // cpu clock
  input wire logic reset_n, // async reset, active low
  input wire adc_seq_pkg::regReq_s regReq, // register access request
  output logic [7:0] regRdData, // read data, cycle after read strobe
  input wire logic compHigh, // comparator: input at or above trial level
  input wire logic waitMode, // light sleep indication
  input wire logic haltMode, // deepest sleep indication
  output adc_seq_pkg::analogCtl_s analogCtl // controls to analog macro
);
  import adc_seq_pkg::*;

  localparam int STAB_W = $clog2(STAB_CYCLES + 1);

  generate
    if (STAB_CYCLES < 1)
    begin : g_bad_stab
      $error("STAB_CYCLES must be at least 1");
    end
  endgenerate

  adcState_e state_ff;
  adcState_e nxt_state;
  logic [STAB_W-1:0] stabCnt_ff;
  logic [STAB_W-1:0] nxt_stabCnt;
  logic [5:0] convCnt_ff;
  logic [5:0] nxt_convCnt;
  logic [7:0] sar_ff;
  logic [7:0] nxt_sar;
  logic [7:0] result_ff;
  logic [7:0] nxt_result;
  logic done_ff;
  logic nxt_done;
  logic powerOn_ff;
  logic nxt_powerOn;
  logic [2:0] channel_ff;
  logic [2:0] nxt_channel;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;

  // address decode
  wire ctrlHit = (regReq.addr == `ADC_CTRL_OFS);
  wire resultHit = (regReq.addr == `ADC_RESULT_OFS);
  wire ctrlWr = regReq.wr && ctrlHit;
  wire resultRd = regReq.rd && resultHit;
  wire ctrlRd = regReq.rd && ctrlHit;
  wire newPower = regReq.wrData[`ADC_PWR_BIT];

  // conversion timing
  wire converting = (state_ff == ST_CONV);
  wire sampling = converting && (convCnt_ff < 6'(`ADC_SAMPLE_CYCLES));
  wire sampleEnd = converting && (convCnt_ff == 6'(`ADC_SAMPLE_CYCLES - 1));
  wire slotEnd = converting && !sampling && (convCnt_ff[1:0] == 2'(`ADC_SLOT_CYCLES - 1));
  wire [2:0] bitIdx = ~convCnt_ff[4:2];
  wire convEnd = converting && (convCnt_ff == 6'(`ADC_CONV_CYCLES - 1));
  // an abort or deep sleep entry in the same cycle discards the finishing conversion
  wire convDone = convEnd && !ctrlWr && !haltMode;
  wire stabDone = (state_ff == ST_STAB) && (stabCnt_ff == STAB_W'(STAB_CYCLES - 1));

  // successive approximation step, one bit per slot
  logic [7:0] decided;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_sar
      // full-scale input keeps every bit, so saturation gives FFh or 00h
      assign decided[gi] = (bitIdx == 3'(gi)) ? (sar_ff[gi] & compHigh) : sar_ff[gi];
      always_comb
      begin
        if (sampleEnd)
          nxt_sar[gi] = (gi == 7);
        else if (slotEnd)
          nxt_sar[gi] = decided[gi] | ((bitIdx != 3'h0) && (3'(gi) == bitIdx - 3'h1));
        else
          nxt_sar[gi] = sar_ff[gi];
      end
    end
  endgenerate

  // control register fields; bits 6, 4, 3 are not stored
  always_comb
  begin
    nxt_powerOn = powerOn_ff;
    nxt_channel = channel_ff;
    if (ctrlWr)
    begin
      nxt_powerOn = newPower;
      nxt_channel = regReq.wrData[`ADC_CHAN_MSB:`ADC_CHAN_LSB];
    end
  end

  // sequencer; waitMode is deliberately not looked at
  always_comb
  begin
    nxt_state = state_ff;
    nxt_stabCnt = stabCnt_ff;
    nxt_convCnt = convCnt_ff;
    case (state_ff)
      ST_OFF:
      begin
        if (powerOn_ff && !haltMode)
        begin
          nxt_state = ST_STAB;
          nxt_stabCnt = '0;
        end
      end
      ST_STAB:
      begin
        nxt_stabCnt = stabCnt_ff + STAB_W'(1);
        if (stabDone)
        begin
          nxt_state = ST_CONV;
          nxt_convCnt = 6'h00;
        end
      end
      ST_CONV:
      begin
        // wraps to zero after the last cycle: back-to-back conversions
        nxt_convCnt = convCnt_ff + 6'h01;
        if (ctrlWr)
          nxt_convCnt = 6'h00;
      end
      default:
      begin
        nxt_state = ST_OFF;
      end
    endcase
    // deep sleep or power off drop back; restart goes through stabilization again
    if (!powerOn_ff || haltMode || (ctrlWr && !newPower))
      nxt_state = ST_OFF;
  end

  // result and done flag; a finishing conversion wins over a result read
  always_comb
  begin
    nxt_result = result_ff;
    nxt_done = done_ff;
    if (resultRd)
      nxt_done = 1'b0;
    if (ctrlWr)
      nxt_done = 1'b0;
    if (convDone)
    begin
      nxt_result = decided;
      nxt_done = 1'b1;
    end
  end

  // read path; unmapped addresses return zero
  wire [7:0] ctrlView = {done_ff, 1'b0, powerOn_ff, 1'b0, 1'b0, channel_ff};
  always_comb
  begin
    if (resultRd)
      nxt_rdData = result_ff;
    else if (ctrlRd)
      nxt_rdData = ctrlView;
    else
      nxt_rdData = 8'h00;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_OFF;
      stabCnt_ff <= '0;
      convCnt_ff <= 6'h00;
      sar_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      stabCnt_ff <= nxt_stabCnt;
      convCnt_ff <= nxt_convCnt;
      sar_ff <= nxt_sar;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      result_ff <= `ADC_RESULT_RST;
      done_ff <= 1'(`ADC_CTRL_RST >> `ADC_DONE_BIT);
      powerOn_ff <= 1'b0;
      channel_ff <= 3'h0;
      rdData_ff <= 8'h00;
    end
    else
    begin
      result_ff <= nxt_result;
      done_ff <= nxt_done;
      powerOn_ff <= nxt_powerOn;
      channel_ff <= nxt_channel;
      rdData_ff <= nxt_rdData;
    end
  end

  // no interrupt output exists: software polls the done flag
  assign regRdData = rdData_ff;
  // analog macro only powered outside deep sleep
  assign analogCtl.powerOn = (state_ff != ST_OFF);
  assign analogCtl.sampling = sampling;
  assign analogCtl.channel = channel_ff;
  assign analogCtl.trial = sar_ff;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  AST_CHAN_FOLLOWS: assert property (ctrlWr |=> analogCtl.channel == $past(regReq.wrData[2:0]))
    else $error("channel select does not follow control write");

  AST_POWER_START: assert property ((state_ff == ST_OFF) && powerOn_ff && !haltMode
    |=> (state_ff == ST_STAB || !powerOn_ff || $past(ctrlWr)) && !converting)
    else $error("power-on did not enter stabilization");

  AST_SAMPLE_LEN: assert property ($rose(converting) |-> sampling [*8])
    else $error("sampling phase shorter than expected");

  AST_DONE_CYCLE: assert property (convDone |-> convCnt_ff == 6'h3F && $past(convCnt_ff, 1) == 6'h3E)
    else $error("conversion ended off the 64th cycle");

  AST_DONE_SETS: assert property (convDone |=> done_ff && result_ff == $past(decided))
    else $error("completion did not set flag and result");

  AST_CTRL_CLR: assert property (ctrlWr |=> !done_ff && (!converting || convCnt_ff == 6'h00))
    else $error("control write did not abort and clear");

  AST_READ_CLR: assert property (resultRd && !convDone && !ctrlWr |=> !done_ff)
    else $error("result read did not clear done flag");

  AST_OFF_STOPS: assert property (!powerOn_ff |=> state_ff == ST_OFF && !analogCtl.powerOn)
    else $error("converter still running with power bit clear");

  AST_HALT_OFF: assert property (haltMode |=> !converting ##1 !converting)
    else $error("conversion ran during deep sleep");

  AST_READ_RESULT: assert property (resultRd |=> regRdData == $past(result_ff))
    else $error("result read returned wrong value");

  AST_RSVD_ZERO: assert property (ctrlRd |=> regRdData[6] == 1'b0 && regRdData[4:3] == 2'h0)
    else $error("reserved control bits read non-zero");

  AST_HOLD_FLAG: assert property (done_ff && !resultRd && !ctrlWr |=> done_ff)
    else $error("done flag dropped without a clear");

  COV_DONE: cover property (convDone);
  COV_BACK_TO_BACK: cover property (convDone ##64 convDone);
  COV_ABORT: cover property (converting && convCnt_ff == 6'h20 && ctrlWr);
  COV_READ_RACE: cover property (convDone && resultRd);
  COV_HALT_EXIT: cover property ($fell(haltMode) && powerOn_ff);

  // counted apart from the sequencer, so a slip in its own counters shows up
  logic [STAB_W-1:0] stabSeen_ff;
  logic [5:0] convAge_ff;

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stabSeen_ff <= '0;
      convAge_ff <= 6'h00;
    end
    else
    begin
      stabSeen_ff <= (state_ff == ST_STAB) ? stabSeen_ff + STAB_W'(1) : '0;
      convAge_ff <= (!converting || ctrlWr || convEnd) ? 6'h00 : convAge_ff + 6'h01;
    end
  end

  AST_STAB_LEN: assert property ($rose(converting) |-> stabSeen_ff == STAB_W'(STAB_CYCLES))
    else $error("stabilization delay has the wrong length");

  AST_STAB_QUIET: assert property (state_ff == ST_STAB |-> !sampling && !convDone)
    else $error("conversion activity during stabilization");

  AST_CONTINUOUS: assert property (convEnd && powerOn_ff && !haltMode && !ctrlWr
    |=> converting && convCnt_ff == 6'h00)
    else $error("next conversion did not follow on its own");

  AST_CONV_AGE: assert property (convEnd |-> convAge_ff == 6'h3F)
    else $error("conversion did not last 64 cycles");

  AST_SAMPLE_STOP: assert property (sampleEnd && !ctrlWr |=> !sampling)
    else $error("sampling ran past its 32 cycles");

  AST_TRIAL_START: assert property (sampleEnd |=> analogCtl.trial == 8'h80)
    else $error("approximation did not start at mid-scale");

  AST_SAR_DECIDE: assert property (slotEnd |=> sar_ff[$past(bitIdx)] == $past(compHigh))
    else $error("trial bit not decided by the comparator");

  AST_DONE_ONLY_END: assert property ($rose(done_ff) |-> $past(convDone))
    else $error("done flag set without a finished conversion");

  AST_OFF_IDLE: assert property (!powerOn_ff |-> !converting)
    else $error("conversion running with power bit clear");

  AST_WAIT_RUNS: assert property (waitMode && converting && !convEnd && !ctrlWr && !haltMode && powerOn_ff
    |=> converting && convCnt_ff == $past(convCnt_ff) + 6'h01)
    else $error("light sleep disturbed the conversion");

  AST_HALT_NO_DONE: assert property (haltMode && !done_ff |=> !done_ff)
    else $error("conversion completed during deep sleep");

  AST_RESTAB: assert property ($fell(haltMode) && powerOn_ff && !ctrlWr
    |-> state_ff == ST_OFF ##1 state_ff == ST_STAB)
    else $error("deep sleep exit skipped stabilization");

  AST_RESULT_RO: assert property (!convDone |=> result_ff == $past(result_ff))
    else $error("result changed without a conversion end");

  AST_IDLE_ZERO: assert property (!regReq.rd |=> regRdData == 8'h00)
    else $error("read data not zero outside a read");

  AST_POWER_BIT: assert property (ctrlWr |=> powerOn_ff == $past(regReq.wrData[5]))
    else $error("power bit does not follow control write");

  AST_CHAN_HOLD: assert property (!ctrlWr |=> $stable(analogCtl.channel))
    else $error("channel changed without a control write");

endmodule

/* verif/adc_input_model.sv */
`timescale 1ns/1ps
module adc_input_model
(
  input wire logic core_clk, // cpu clock
  input wire adc_seq_pkg::analogCtl_s analogCtl, // controls from block
  input wire logic [7:0] level [8], // input level per channel
  output logic compHigh // comparator result
);
  import adc_seq_pkg::*;
  logic lastCmp = 1'b0;
  logic cmp;
  // levels saturate at 00h and FFh, so the extremes clip without overflow
  assign cmp = level[analogCtl.channel] >= analogCtl.trial;
  // unpowered comparator flips each cycle so a stale value never passes
  assign compHigh = analogCtl.powerOn ? cmp : ~lastCmp;
  always @(posedge core_clk)
  begin
    lastCmp <= compHigh;
  end
endmodule

/* verif/tb_adc_sequencer_control.sv */
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("mismatch at %0t: got %h exp %h", $time, a, e); \
    end \
  end
module tb_adc_sequencer_control;
  import adc_seq_pkg::*;
  logic core_clk;
  logic reset_n;
  regReq_s regReq;
  logic [7:0] regRdData;
  logic compHigh, waitMode, haltMode;
  analogCtl_s analogCtl;
  logic [7:0] level [8];
  logic [7:0] rdv;
  int failures, check_count;
  adc_sequencer_control #(.STAB_CYCLES(10)) DUT (.core_clk(core_clk), .reset_n(reset_n), .regReq(regReq),
    .regRdData(regRdData), .compHigh(compHigh), .waitMode(waitMode), .haltMode(haltMode), .analogCtl(analogCtl));
  adc_input_model model (.core_clk(core_clk), .analogCtl(analogCtl), .level(level), .compHigh(compHigh));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    #1 rdv = regRdData;
  endtask
  task automatic wait_done;
    int i;
    i = 0;
    do
    begin
      rd(8'h71);
      i++;
    end while (rdv[7] !== 1'b1 && i < 300);
    `CHK(rdv[7], 1'b1)
  endtask
  task automatic t_reset;
    rd(8'h70);
    `CHK(rdv, 8'h00)
    rd(8'h71);
    `CHK(rdv, 8'h00)
    `CHK(analogCtl.powerOn, 1'b0)
    rd(8'h55);
    `CHK(rdv, 8'h00)
  endtask
  task automatic t_channels;
    @(posedge core_clk);
    waitMode <= 1'b1;
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(8'h71, 8'h20 | 8'(ch));
      `CHK(analogCtl.channel, 3'(ch))
      wait_done();
      rd(8'h70);
      `CHK(rdv, level[ch])
      rd(8'h71);
      `CHK(rdv, 8'h20 | 8'(ch))
    end
    @(posedge core_clk);
    waitMode <= 1'b0;
  endtask
  task automatic t_timing;
    logic p;
    int n;
    int hi;
    p = 1'b1;
    n = 1;
    hi = 1;
    repeat (200)
    begin
      @(posedge core_clk);
      #1;
      if (analogCtl.sampling && !p) break;
      p = analogCtl.sampling;
    end
    p = 1'b1;
    repeat (200)
    begin
      @(posedge core_clk);
      #1;
      if (analogCtl.sampling && !p) break;
      p = analogCtl.sampling;
      n++;
      hi += analogCtl.sampling;
    end
    `CHK(n, 64)
    `CHK(hi, 32)
  endtask
  task automatic t_abort;
    wr(8'h71, 8'h22);
    repeat (40) @(posedge core_clk);
    wr(8'h71, 8'h23);
    wait_done();
    rd(8'h70);
    `CHK(rdv, level[3])
    wr(8'h71, 8'h23);
    rd(8'h71);
    `CHK(rdv, 8'h23)
    wr(8'h71, 8'h33);
    rd(8'h71);
    `CHK(rdv, 8'h23)
    wr(8'h70, 8'h11);
    rd(8'h70);
    `CHK(rdv, level[3])
  endtask
  task automatic t_overwrite;
    wr(8'h71, 8'h22);
    wait_done();
    level[2] = 8'h3C;
    repeat (140) @(posedge core_clk);
    rd(8'h71);
    `CHK(rdv[7], 1'b1)
    rd(8'h70);
    `CHK(rdv, 8'h3C)
  endtask
  task automatic t_halt;
    @(posedge core_clk);
    haltMode <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(analogCtl.powerOn, 1'b0)
    repeat (50) @(posedge core_clk);
    haltMode <= 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    `CHK(analogCtl.sampling, 1'b0)
    wait_done();
    rd(8'h70);
    `CHK(rdv, 8'h3C)
  endtask
  task automatic t_off;
    wr(8'h71, 8'h02);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(analogCtl.powerOn, 1'b0)
    repeat (200) @(posedge core_clk);
    rd(8'h71);
    `CHK(rdv, 8'h02)
  endtask
  task automatic stop_test;
    $display("failures %0d, comparisons %0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    // generous bound; the whole sequence needs under two thousand cycles
    #(30000 * 5);
    failures++;
    stop_test();
  end
  initial
  begin
    failures = 0;
    check_count = 0;
    reset_n = 1'b0;
    regReq = '0;
    waitMode = 1'b0;
    haltMode = 1'b0;
    level = '{8'h00, 8'hFF, 8'h5A, 8'hA5, 8'h01, 8'hFE, 8'h80, 8'h7F};
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_channels();
    t_timing();
    t_abort();
    t_overwrite();
    t_halt();
    t_off();
    stop_test();
  end
endmodule
